// *** sched_pkg.sv ***
// Purpose: Shared constants and types for the fieldbus message scheduler
// Assumes: 100 MHz module clock
// Notes: Refresh periods are defaults only; the top exposes them as parameters
package sched_pkg;
	// Clock and time base
	localparam int CLK_HZ = 100_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int MS_REFRESH_US = 10_000;
	localparam int PEER_REFRESH_US = 20_000;
	localparam int MS_REFRESH_CYC = MS_REFRESH_US * CYC_PER_US;
	localparam int PEER_REFRESH_CYC = PEER_REFRESH_US * CYC_PER_US;
	localparam int SYNC_STAGES = 2;

	// Field widths
	localparam int NODE_W = 6;
	localparam int NODES = 64;
	localparam int MSG_W = 11;
	localparam int DATA_W = 64;
	localparam int BT_W = 10;

	// Selector decoding
	localparam logic [3:0] RATE_125K = 4'h0;
	localparam logic [3:0] RATE_250K = 4'h1;
	localparam logic [3:0] RATE_500K = 4'h2;
	localparam logic [BT_W-1:0] BT_125K = BT_W'(CLK_HZ / 125_000);
	localparam logic [BT_W-1:0] BT_250K = BT_W'(CLK_HZ / 250_000);
	localparam logic [BT_W-1:0] BT_500K = BT_W'(CLK_HZ / 500_000);
	localparam logic [BT_W-1:0] BT_NONE = 10'h000;
	localparam logic [7:0] NODE_ADDR_MAX = 8'h3f;
	localparam logic [3:0] MODNUM_CH_MAX = 4'h3;
	localparam logic [3:0] MODNUM_TM_LO = 4'h8;
	localparam logic [3:0] MODNUM_TM_HI = 4'hb;
	localparam logic [NODE_W-1:0] NODE_LAST = 6'h3f;
	localparam logic [NODE_W-1:0] DEST_ALL = 6'h00;

	// Frame kinds seen by the link controller
	typedef enum logic [2:0] {FR_POLL_REQ, FR_POLL_RSP, FR_STROBE_REQ, FR_STROBE_RSP,
		FR_PEER, FR_EXPLICIT, FR_COS, FR_CYCLIC} frame_kind_t;
endpackage

// *** refresh_if.sv ***
// Purpose: Run request and period tick between scheduler and refresh timer
// Assumes: Single clock domain
// Notes: Tick is a one-cycle pulse
`timescale 1ns/1ns
interface refresh_if;
	logic run;
	logic tick;
	modport timer(input run, output tick);
	modport user(output run, input tick);
endinterface

// *** refresh_timer.sv ***
// Purpose: Free-running refresh period counter
// Assumes: PERIOD of at least one cycle
// Notes: Restarts from zero whenever run drops
`timescale 1ns/1ns
module refresh_timer #(
	parameter int PERIOD = 1000
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// Timer side of the refresh link
	refresh_if.timer tif
);
	logic [31:0] cnt_reg;
	logic tick_reg;

	// Count periods while running, pulse at each period end
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt_reg <= 32'h0000_0000;
			tick_reg <= 1'b0;
		end else if (!tif.run) begin
			cnt_reg <= 32'h0000_0000;
			tick_reg <= 1'b0;
		end else if (cnt_reg == 32'(PERIOD - 1)) begin
			cnt_reg <= 32'h0000_0000;
			tick_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 32'h0000_0001;
			tick_reg <= 1'b0;
		end
	end

	assign tif.tick = tick_reg;
endmodule

// *** pin_sync.sv ***
// Purpose: Two-flop synchroniser for slow switch pins
// Assumes: Inputs change rarely (set with power off)
// Notes: First stage is read by the second stage only
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// Data
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	// Two stages to settle metastability
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			meta_reg <= '0;
			q_reg <= '0;
		end else begin
			meta_reg <= d_in;
			q_reg <= meta_reg;
		end
	end

	assign q_out = q_reg;
endmodule

// *** fieldbus_scan_scheduler.sv ***
// Purpose: Poll, bit-strobe, peer and explicit message scheduling for a fieldbus node
// Assumes: Same-clock link controller with valid/ready transmit and valid receive
// Notes: Switch pins are synchronised; configuration inputs are same-clock
`timescale 1ns/1ns
module fieldbus_scan_scheduler #(
	parameter int MS_PERIOD = sched_pkg::MS_REFRESH_CYC,
	parameter int PEER_PERIOD = sched_pkg::PEER_REFRESH_CYC
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// Switch pins
	input wire logic [7:0] node_address_selector_in,
	input wire logic [3:0] bit_rate_selector_in,
	input wire logic [3:0] module_number_selector_in,
	// Roles and transmission types
	input wire logic master_role_in,
	input wire logic slave_role_in,
	input wire logic peer_role_in,
	input wire logic type_poll_in,
	input wire logic type_strobe_tx_in,
	input wire logic type_strobe_rx_in,
	input wire logic type_peer_tx_in,
	input wire logic type_peer_rx_in,
	input wire logic fw_v2_in,
	// Exchange data
	input wire logic [sched_pkg::NODES-1:0] slave_mask_in,
	input wire logic [sched_pkg::DATA_W-1:0] poll_data_in,
	input wire logic [sched_pkg::DATA_W-1:0] strobe_data_in,
	input wire logic [sched_pkg::DATA_W-1:0] slave_data_in,
	input wire logic [sched_pkg::MSG_W-1:0] peer_tx_msg_id_in,
	input wire logic [sched_pkg::DATA_W-1:0] peer_tx_data_in,
	input wire logic [sched_pkg::MSG_W-1:0] peer_rx_msg_id_in,
	input wire logic [sched_pkg::NODE_W-1:0] peer_rx_node_in,
	// Explicit message request
	input wire logic expl_req_in,
	input wire logic [sched_pkg::NODE_W-1:0] expl_dest_in,
	input wire logic [sched_pkg::DATA_W-1:0] expl_data_in,
	output logic expl_busy_out,
	// Transmit to link controller
	output logic tx_valid_out,
	input wire logic tx_ready_in,
	output sched_pkg::frame_kind_t tx_kind_out,
	output logic [sched_pkg::NODE_W-1:0] tx_dest_out,
	output logic [sched_pkg::MSG_W-1:0] tx_msg_id_out,
	output logic [sched_pkg::DATA_W-1:0] tx_data_out,
	// Receive from link controller
	input wire logic rx_valid_in,
	input sched_pkg::frame_kind_t rx_kind_in,
	input wire logic [sched_pkg::NODE_W-1:0] rx_src_in,
	input wire logic [sched_pkg::NODE_W-1:0] rx_dest_in,
	input wire logic [sched_pkg::MSG_W-1:0] rx_msg_id_in,
	input wire logic [sched_pkg::DATA_W-1:0] rx_data_in,
	// Delivered frames
	output logic rcv_valid_out,
	output sched_pkg::frame_kind_t rcv_kind_out,
	output logic [sched_pkg::NODE_W-1:0] rcv_src_out,
	output logic [sched_pkg::DATA_W-1:0] rcv_data_out,
	// Status
	output logic param_error_out,
	output logic [sched_pkg::BT_W-1:0] bit_time_cycles_out,
	output logic [sched_pkg::NODE_W-1:0] node_id_out,
	output logic module_network_status_indicator_green_out,
	output logic module_network_status_indicator_red_out
);
	import sched_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_WAIT} tx_state_t;

	logic [7:0] addr_s;
	logic [3:0] br_s, mn_s;
	logic rate_bad, addr_bad, mod_bad, mode_bad, type_bad, fw_bad, cfg_err;
	logic slave_mode, run_w;
	logic param_err_reg, stop_reg, slave_mode_reg;
	logic scan_pend_reg, strobe_pend_reg, peer_pend_reg, rsp_pend_reg, expl_pend_reg;
	logic take_rsp, take_scan, take_strobe, take_peer, take_expl;
	logic [NODE_W-1:0] rsp_dest_reg, scan_idx_reg, expl_dest_reg;
	logic [DATA_W-1:0] expl_data_reg;
	logic scan_on_reg;
	logic poll_for_me;
	tx_state_t st_reg;

	refresh_if ms_if();
	refresh_if peer_if();

	// Switch pins come from outside the clock domain
	pin_sync #(.W(16)) u_sw_sync (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.d_in({node_address_selector_in, bit_rate_selector_in, module_number_selector_in}),
		.q_out({addr_s, br_s, mn_s})
	);

	// Selector and configuration checks
	always_comb begin
		rate_bad = br_s > RATE_500K;
		addr_bad = addr_s > NODE_ADDR_MAX;
		mod_bad = (mn_s > MODNUM_CH_MAX && mn_s < MODNUM_TM_LO) || mn_s > MODNUM_TM_HI;
		mode_bad = (slave_role_in && (master_role_in || peer_role_in)) ||
			!(slave_role_in || master_role_in || peer_role_in);
		slave_mode = slave_role_in && !master_role_in && !peer_role_in;
		type_bad = slave_mode && (type_strobe_tx_in || type_strobe_rx_in ||
			type_peer_tx_in || type_peer_rx_in);
		fw_bad = !fw_v2_in && (slave_role_in || type_strobe_tx_in || type_strobe_rx_in);
		cfg_err = rate_bad || addr_bad || mode_bad || type_bad || fw_bad;
	end

	// Registered status; a bad setting holds off all exchanges
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			param_err_reg <= 1'b0;
			stop_reg <= 1'b0;
			slave_mode_reg <= 1'b0;
			node_id_out <= 6'h00;
			bit_time_cycles_out <= BT_NONE;
			module_network_status_indicator_green_out <= 1'b0;
			module_network_status_indicator_red_out <= 1'b0;
		end else begin
			param_err_reg <= cfg_err;
			stop_reg <= mod_bad;
			slave_mode_reg <= slave_mode;
			node_id_out <= addr_s[NODE_W-1:0];
			case (br_s)
				RATE_125K: bit_time_cycles_out <= BT_125K;
				RATE_250K: bit_time_cycles_out <= BT_250K;
				RATE_500K: bit_time_cycles_out <= BT_500K;
				default: bit_time_cycles_out <= BT_NONE;
			endcase
			module_network_status_indicator_green_out <= !cfg_err && !mod_bad;
			module_network_status_indicator_red_out <= mod_bad;
		end
	end

	assign param_error_out = param_err_reg;
	assign run_w = !param_err_reg && !stop_reg;

	// Refresh timers need no software start
	assign ms_if.run = run_w && master_role_in && (type_poll_in || type_strobe_tx_in);
	assign peer_if.run = run_w && peer_role_in && type_peer_tx_in;
	refresh_timer #(.PERIOD(MS_PERIOD)) u_ms_timer (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.tif(ms_if)
	);
	refresh_timer #(.PERIOD(PEER_PERIOD)) u_peer_timer (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.tif(peer_if)
	);

	// Poll aimed at this node while acting as slave
	assign poll_for_me = rx_valid_in && rx_kind_in == FR_POLL_REQ && rx_dest_in == node_id_out &&
		slave_mode_reg && run_w;

	// Pending work; a new event wins over the clear in the same cycle
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			scan_pend_reg <= 1'b0;
			strobe_pend_reg <= 1'b0;
			peer_pend_reg <= 1'b0;
			rsp_pend_reg <= 1'b0;
			expl_pend_reg <= 1'b0;
			rsp_dest_reg <= 6'h00;
			expl_dest_reg <= 6'h00;
			expl_data_reg <= '0;
		end else if (!run_w) begin
			scan_pend_reg <= 1'b0;
			strobe_pend_reg <= 1'b0;
			peer_pend_reg <= 1'b0;
			rsp_pend_reg <= 1'b0;
			expl_pend_reg <= 1'b0;
		end else begin
			scan_pend_reg <= (scan_pend_reg && !take_scan) || (ms_if.tick && type_poll_in);
			strobe_pend_reg <= (strobe_pend_reg && !take_strobe) || (ms_if.tick && type_strobe_tx_in);
			peer_pend_reg <= (peer_pend_reg && !take_peer) || peer_if.tick;
			rsp_pend_reg <= (rsp_pend_reg && !take_rsp) || poll_for_me;
			// Slave mode keeps to polled exchange, so explicit requests are ignored there
			expl_pend_reg <= (expl_pend_reg && !take_expl) || (expl_req_in && !slave_mode_reg);
			if (poll_for_me) begin
				rsp_dest_reg <= rx_src_in;
			end
			if (expl_req_in && !expl_pend_reg) begin
				expl_dest_reg <= expl_dest_in;
				expl_data_reg <= expl_data_in;
			end
		end
	end

	assign expl_busy_out = expl_pend_reg;

	// Idle arbitration: slave answer first, then scan, strobe, peer, explicit
	always_comb begin
		take_rsp = 1'b0;
		take_scan = 1'b0;
		take_strobe = 1'b0;
		take_peer = 1'b0;
		take_expl = 1'b0;
		if (st_reg == ST_IDLE && run_w) begin
			if (rsp_pend_reg) begin
				take_rsp = 1'b1;
			end else if (scan_pend_reg) begin
				take_scan = 1'b1;
			end else if (strobe_pend_reg) begin
				take_strobe = 1'b1;
			end else if (peer_pend_reg) begin
				take_peer = 1'b1;
			end else if (expl_pend_reg) begin
				take_expl = 1'b1;
			end
		end
	end

	// Transmit sequencer; a stop aborts an unaccepted frame at once
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_reg <= ST_IDLE;
			scan_idx_reg <= 6'h00;
			scan_on_reg <= 1'b0;
			tx_valid_out <= 1'b0;
			tx_kind_out <= FR_POLL_REQ;
			tx_dest_out <= 6'h00;
			tx_msg_id_out <= '0;
			tx_data_out <= '0;
		end else if (!run_w) begin
			st_reg <= ST_IDLE;
			scan_on_reg <= 1'b0;
			tx_valid_out <= 1'b0;
		end else begin
			case (st_reg)
				ST_IDLE: begin
					if (take_rsp) begin
						tx_valid_out <= 1'b1;
						tx_kind_out <= FR_POLL_RSP;
						tx_dest_out <= rsp_dest_reg;
						tx_data_out <= slave_data_in;
						st_reg <= ST_WAIT;
					end else if (take_scan) begin
						scan_idx_reg <= 6'h00;
						scan_on_reg <= 1'b1;
						st_reg <= ST_SCAN;
					end else if (take_strobe) begin
						tx_valid_out <= 1'b1;
						tx_kind_out <= FR_STROBE_REQ;
						tx_dest_out <= DEST_ALL;
						tx_data_out <= strobe_data_in;
						st_reg <= ST_WAIT;
					end else if (take_peer) begin
						tx_valid_out <= 1'b1;
						tx_kind_out <= FR_PEER;
						tx_dest_out <= DEST_ALL;
						tx_msg_id_out <= peer_tx_msg_id_in;
						tx_data_out <= peer_tx_data_in;
						st_reg <= ST_WAIT;
					end else if (take_expl) begin
						tx_valid_out <= 1'b1;
						tx_kind_out <= FR_EXPLICIT;
						tx_dest_out <= expl_dest_reg;
						tx_data_out <= expl_data_reg;
						st_reg <= ST_WAIT;
					end
				end
				ST_SCAN: begin
					if (slave_mask_in[scan_idx_reg]) begin
						tx_valid_out <= 1'b1;
						tx_kind_out <= FR_POLL_REQ;
						tx_dest_out <= scan_idx_reg;
						tx_data_out <= poll_data_in;
						st_reg <= ST_WAIT;
					end else if (scan_idx_reg == NODE_LAST) begin
						scan_on_reg <= 1'b0;
						st_reg <= ST_IDLE;
					end else begin
						scan_idx_reg <= scan_idx_reg + 6'h01;
					end
				end
				ST_WAIT: begin
					if (tx_ready_in) begin
						tx_valid_out <= 1'b0;
						if (scan_on_reg && scan_idx_reg != NODE_LAST) begin
							scan_idx_reg <= scan_idx_reg + 6'h01;
							st_reg <= ST_SCAN;
						end else begin
							scan_on_reg <= 1'b0;
							st_reg <= ST_IDLE;
						end
					end
				end
				default: st_reg <= ST_IDLE;
			endcase
		end
	end

	// Receive filter; unexpected kinds are dropped silently
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rcv_valid_out <= 1'b0;
			rcv_kind_out <= FR_POLL_REQ;
			rcv_src_out <= 6'h00;
			rcv_data_out <= '0;
		end else begin
			rcv_valid_out <= 1'b0;
			if (rx_valid_in && run_w) begin
				rcv_kind_out <= rx_kind_in;
				rcv_src_out <= rx_src_in;
				rcv_data_out <= rx_data_in;
				case (rx_kind_in)
					FR_POLL_REQ: rcv_valid_out <= poll_for_me;
					FR_POLL_RSP: rcv_valid_out <= !slave_mode_reg && type_poll_in &&
						rx_dest_in == node_id_out;
					FR_STROBE_RSP: rcv_valid_out <= !slave_mode_reg && type_strobe_rx_in;
					FR_PEER: rcv_valid_out <= !slave_mode_reg && type_peer_rx_in &&
						rx_msg_id_in == peer_rx_msg_id_in && rx_src_in == peer_rx_node_in;
					FR_EXPLICIT: rcv_valid_out <= !slave_mode_reg && rx_dest_in == node_id_out;
					default: rcv_valid_out <= 1'b0;
				endcase
			end
		end
	end

	// Checks
	sequence s_my_poll;
		poll_for_me && st_reg == ST_IDLE && !rsp_pend_reg;
	endsequence
	sequence s_answer;
		tx_valid_out && tx_kind_out == FR_POLL_RSP;
	endsequence
	property p_slave_answer;
		@(posedge mclk_in) disable iff (sys_rst_in) s_my_poll ##1 run_w |-> ##1 s_answer;
	endproperty
	a_slave_answer: assert property (p_slave_answer) else $error("poll not answered");
	property p_slave_only_poll;
		@(posedge mclk_in) disable iff (sys_rst_in)
			$rose(tx_valid_out) && $past(slave_mode_reg) |-> tx_kind_out == FR_POLL_RSP;
	endproperty
	a_slave_only_poll: assert property (p_slave_only_poll) else $error("slave sent non-poll");
	property p_peer_filter;
		@(posedge mclk_in) disable iff (sys_rst_in) rx_valid_in && rx_kind_in == FR_PEER &&
			(rx_msg_id_in != peer_rx_msg_id_in || rx_src_in != peer_rx_node_in) |=> !rcv_valid_out;
	endproperty
	a_peer_filter: assert property (p_peer_filter) else $error("peer frame not discarded");
	property p_stop_quiet;
		@(posedge mclk_in) disable iff (sys_rst_in) stop_reg |=> !tx_valid_out && module_network_status_indicator_red_out;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet) else $error("transmit during stop");
	property p_role_combo;
		@(posedge mclk_in) disable iff (sys_rst_in) slave_role_in && (master_role_in || peer_role_in) |=> param_error_out;
	endproperty
	a_role_combo: assert property (p_role_combo) else $error("bad roles not flagged");
	property p_fw_level;
		@(posedge mclk_in) disable iff (sys_rst_in) !fw_v2_in && type_strobe_tx_in |=> param_error_out;
	endproperty
	a_fw_level: assert property (p_fw_level) else $error("strobe allowed on old firmware");
	property p_rate_decode;
		@(posedge mclk_in) disable iff (sys_rst_in) br_s == RATE_250K |=> bit_time_cycles_out == BT_250K;
	endproperty
	a_rate_decode: assert property (p_rate_decode) else $error("wrong bit time");
	property p_scan_start;
		@(posedge mclk_in) disable iff (sys_rst_in) take_scan |=> st_reg == ST_SCAN && scan_idx_reg == 6'h00;
	endproperty
	a_scan_start: assert property (p_scan_start) else $error("scan did not start at node 0");
	property p_poll_data;
		@(posedge mclk_in) disable iff (sys_rst_in)
			$rose(tx_valid_out) && tx_kind_out == FR_POLL_REQ |-> tx_data_out == $past(poll_data_in);
	endproperty
	a_poll_data: assert property (p_poll_data) else $error("poll data wrong");
	property p_peer_tick;
		@(posedge mclk_in) disable iff (sys_rst_in) peer_if.tick && run_w |=> peer_pend_reg || !run_w;
	endproperty
	a_peer_tick: assert property (p_peer_tick) else $error("peer refresh lost");
endmodule

// *** link_partner.sv ***
// Purpose: Remote bus nodes as seen through the link controller
// Assumes: Driven at the falling clock edge, sampled at the rising edge
// Notes: Ready stalls at random; released receive lines show inverted data
`timescale 1ns/1ns
module link_partner (
	// Clock
	input wire logic mclk_in,
	// Frames from the scheduler
	input wire logic tx_valid_in,
	input sched_pkg::frame_kind_t tx_kind_in,
	input wire logic [sched_pkg::NODE_W-1:0] tx_dest_in,
	output logic tx_ready_out,
	// Frames towards the scheduler
	output logic rx_valid_out,
	output sched_pkg::frame_kind_t rx_kind_out,
	output logic [sched_pkg::NODE_W-1:0] rx_src_out,
	output logic [sched_pkg::NODE_W-1:0] rx_dest_out,
	output logic [sched_pkg::MSG_W-1:0] rx_msg_id_out,
	output logic [sched_pkg::DATA_W-1:0] rx_data_out
);
	import sched_pkg::*;
	localparam logic [NODE_W-1:0] MASTER_NODE = 6'h05;
	int seed = 66034;
	logic [8:0] reqq[$];
	logic [8:0] r;

	// One frame per rising edge with both valid and ready
	always @(posedge mclk_in) begin
		if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1)
			reqq.push_back({tx_kind_in, tx_dest_in});
	end

	// Random stall, so slow acceptance is exercised too
	always @(negedge mclk_in) begin
		tx_ready_out <= ($random(seed) & 3) != 0;
	end

	// One-cycle frame pulse; lines never keep the old value afterwards
	task automatic send(input frame_kind_t k, input logic [NODE_W-1:0] s, input logic [NODE_W-1:0] d,
		input logic [MSG_W-1:0] m, input logic [DATA_W-1:0] v);
		@(negedge mclk_in);
		rx_kind_out = k;
		{rx_src_out, rx_dest_out, rx_msg_id_out, rx_data_out} = {s, d, m, v};
		rx_valid_out = 1'b1;
		@(negedge mclk_in);
		rx_valid_out = 1'b0;
		rx_kind_out = frame_kind_t'(~k);
		{rx_src_out, rx_dest_out, rx_msg_id_out, rx_data_out} = ~{s, d, m, v};
	endtask

	// Slaves answer only once their request has gone by
	initial begin
		{rx_valid_out, rx_src_out, rx_dest_out, rx_msg_id_out, rx_data_out} = '0;
		rx_kind_out = FR_POLL_REQ;
		tx_ready_out = 1'b0;
		forever begin
			@(negedge mclk_in);
			while (reqq.size() != 0) begin
				r = reqq.pop_front();
				if (r[8:6] == FR_POLL_REQ) begin
					send(FR_POLL_RSP, r[5:0], MASTER_NODE, 11'h000, {58'h155, r[5:0]});
				end else if (r[8:6] == FR_STROBE_REQ) begin
					send(FR_STROBE_RSP, 6'h01, MASTER_NODE, 11'h000, {58'h155, 6'h01});
					send(FR_STROBE_RSP, 6'h02, MASTER_NODE, 11'h000, {58'h155, 6'h02});
				end
			end
		end
	end
endmodule

// *** fieldbus_scan_scheduler_test.sv ***
// Purpose: Self-checking bench for the fieldbus message scheduler
// Assumes: Short refresh periods stand in for the long defaults
// Notes: Frames seen are queued and compared with the bench model queues
`timescale 1ns/1ns
module fieldbus_scan_scheduler_test;
	import sched_pkg::*;
	localparam int MS_P = 200;
	localparam int PEER_P = 400;
	localparam logic [8:0] TC [13] = '{9'h165, 9'h165, 9'h165, 9'h165, 9'h165, 9'h165, 9'h165,
		9'h1a1, 9'h0e1, 9'h021, 9'h0a0, 9'h174, 9'h0a5};
	localparam logic [15:0] TSW [13] = '{16'h0500, 16'h0510, 16'h0520, 16'h0530, 16'h4000, 16'h0504, 16'h0508,
		16'h0500, 16'h0500, 16'h0500, 16'h0500, 16'h0500, 16'h0500};
	localparam logic [12:0] TERR = 13'h1f98;
	typedef logic [83:0] frame_t;
	logic mclk_in, sys_rst_in, master_role_in, slave_role_in, peer_role_in, type_poll_in, fw_v2_in;
	logic type_strobe_tx_in, type_strobe_rx_in, type_peer_tx_in, type_peer_rx_in, expl_req_in, expl_busy_out;
	logic [7:0] node_address_selector_in;
	logic [3:0] bit_rate_selector_in, module_number_selector_in;
	logic [NODES-1:0] slave_mask_in;
	logic [DATA_W-1:0] poll_data_in, strobe_data_in, slave_data_in, peer_tx_data_in, expl_data_in;
	logic [DATA_W-1:0] tx_data_out, rx_data_in, rcv_data_out;
	logic [MSG_W-1:0] peer_tx_msg_id_in, peer_rx_msg_id_in, tx_msg_id_out, rx_msg_id_in;
	logic [NODE_W-1:0] peer_rx_node_in, expl_dest_in, tx_dest_out, rx_src_in, rx_dest_in, rcv_src_out, node_id_out;
	logic tx_valid_out, tx_ready_in, rx_valid_in, rcv_valid_out, param_error_out, ok;
	logic module_network_status_indicator_green_out, module_network_status_indicator_red_out;
	logic [BT_W-1:0] bit_time_cycles_out, bt;
	frame_kind_t tx_kind_out, rx_kind_in, rcv_kind_out;
	frame_t txq[$], rcvq[$], expq[$];
	frame_t f;
	int bad_count, n_tests, seed, np, ns, npr;

	fieldbus_scan_scheduler #(.MS_PERIOD(MS_P), .PEER_PERIOD(PEER_P)) fieldbus_scan_scheduler_inst (
		.mclk_in, .sys_rst_in, .node_address_selector_in, .bit_rate_selector_in, .module_number_selector_in,
		.master_role_in, .slave_role_in, .peer_role_in, .type_poll_in, .type_strobe_tx_in, .type_strobe_rx_in,
		.type_peer_tx_in, .type_peer_rx_in, .fw_v2_in, .slave_mask_in, .poll_data_in, .strobe_data_in,
		.slave_data_in, .peer_tx_msg_id_in, .peer_tx_data_in, .peer_rx_msg_id_in, .peer_rx_node_in,
		.expl_req_in, .expl_dest_in, .expl_data_in, .expl_busy_out, .tx_valid_out, .tx_ready_in, .tx_kind_out,
		.tx_dest_out, .tx_msg_id_out, .tx_data_out, .rx_valid_in, .rx_kind_in, .rx_src_in, .rx_dest_in,
		.rx_msg_id_in, .rx_data_in, .rcv_valid_out, .rcv_kind_out, .rcv_src_out, .rcv_data_out,
		.param_error_out, .bit_time_cycles_out, .node_id_out, .module_network_status_indicator_green_out,
		.module_network_status_indicator_red_out);

	link_partner link_partner_inst (.mclk_in, .tx_valid_in(tx_valid_out), .tx_kind_in(tx_kind_out),
		.tx_dest_in(tx_dest_out), .tx_ready_out(tx_ready_in), .rx_valid_out(rx_valid_in), .rx_kind_out(rx_kind_in),
		.rx_src_out(rx_src_in), .rx_dest_out(rx_dest_in), .rx_msg_id_out(rx_msg_id_in), .rx_data_out(rx_data_in));

	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end

	// Message id kept only on peer frames, where it means something
	always @(posedge mclk_in) begin
		if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1)
			txq.push_back({tx_kind_out, tx_dest_out, tx_kind_out == FR_PEER ? tx_msg_id_out : 11'h000, tx_data_out});
		if (rcv_valid_out === 1'b1)
			rcvq.push_back({rcv_kind_out, rcv_src_out, 11'h000, rcv_data_out});
	end

	task automatic chk(input frame_t got, input frame_t exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmpq(input frame_t got[$], input frame_t exp[$]);
		chk(frame_t'(got.size()), frame_t'(exp.size()));
		foreach (exp[i])
			if (i < got.size())
				chk(got[i], exp[i]);
	endtask

	// Switches are meant to change only with power off, so every setting gets a fresh reset
	task automatic setup(input logic [8:0] c, input logic [15:0] sw);
		@(negedge mclk_in);
		{master_role_in, slave_role_in, peer_role_in, type_poll_in, type_strobe_tx_in, type_strobe_rx_in,
			type_peer_tx_in, type_peer_rx_in, fw_v2_in} = c;
		{node_address_selector_in, bit_rate_selector_in, module_number_selector_in} = sw;
		sys_rst_in = 1'b1;
		repeat (2) @(negedge mclk_in);
		sys_rst_in = 1'b0;
		repeat (5) @(negedge mclk_in);
		txq.delete();
		rcvq.delete();
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Whole run is near 4100 cycles; about five times that means a hang
	initial begin
		repeat (20000) @(posedge mclk_in);
		bad_count++;
		report_and_stop();
	end

	initial begin
		{bad_count, n_tests, seed} = {32'd0, 32'd0, 32'd66034};
		{sys_rst_in, expl_req_in, expl_dest_in, peer_rx_msg_id_in, peer_rx_node_in} = '0;
		setup(9'h000, 16'h0000);
		poll_data_in = {$random(seed), $random(seed)};
		{strobe_data_in, slave_data_in} = {$random(seed), $random(seed), $random(seed), $random(seed)};
		{peer_tx_data_in, expl_data_in} = {$random(seed), $random(seed), $random(seed), $random(seed)};
		peer_tx_msg_id_in = 11'($random(seed));
		slave_mask_in = {32'h8000_0000, 32'h0000_0001 | (32'h0000_0f00 & $random(seed))};
		setup(9'h17d, 16'h0500);
		for (int n = 0; n < NODES; n++)
			if (slave_mask_in[n])
				expq.push_back({FR_POLL_REQ, 6'(n), 11'h000, poll_data_in});
		repeat (760) @(negedge mclk_in);
		{np, ns, npr} = '0;
		foreach (txq[i]) begin
			f = txq[i];
			if (f[83:81] == FR_POLL_REQ) begin
				chk(f, expq[np % expq.size()]);
				np++;
			end else if (f[83:81] == FR_STROBE_REQ) begin
				chk(f, {FR_STROBE_REQ, DEST_ALL, 11'h000, strobe_data_in});
				ns++;
			end else begin
				chk(f, {FR_PEER, DEST_ALL, peer_tx_msg_id_in, peer_tx_data_in});
				npr++;
			end
		end
		chk(frame_t'({np[15:0], ns[15:0], npr[15:0]}), frame_t'({16'(3 * expq.size()), 16'd3, 16'd1}));
		{np, ns} = '0;
		foreach (rcvq[i]) begin
			f = rcvq[i];
			chk(f, {f[83:81] == FR_STROBE_RSP ? FR_STROBE_RSP : FR_POLL_RSP, f[80:75], 11'h000, 58'h155, f[80:75]});
			if (f[83:81] == FR_STROBE_RSP)
				ns++;
			else
				np++;
		end
		chk(frame_t'({np[15:0], ns[15:0]}), frame_t'({16'(3 * expq.size()), 16'd6}));
		$display("test master-peer scan done");
		// Peer reception filter, refused kinds, explicit both ways
		{peer_rx_msg_id_in, peer_rx_node_in, expl_dest_in} = {11'h123, 6'h09, 6'h0c};
		setup(9'h043, 16'h0500);
		expq.delete();
		for (int k = 0; k < 8; k++) begin
			f = {FR_PEER, 6'h09, 11'h123, poll_data_in ^ 64'(k)};
			f[74:64] = k == 1 ? 11'h124 : f[74:64];
			f[80:75] = k == 2 ? 6'h0a : f[80:75];
			f[83:81] = k == 3 ? FR_COS : k == 4 ? FR_CYCLIC : k == 5 ? FR_STROBE_REQ : k == 7 ? FR_EXPLICIT : f[83:81];
			if (k == 0 || k >= 6)
				expq.push_back({f[83:75], 11'h000, f[63:0]});
			link_partner_inst.send(frame_kind_t'(f[83:81]), f[80:75], 6'h05, f[74:64], f[63:0]);
		end
		expl_req_in = 1'b1;
		@(negedge mclk_in);
		expl_req_in = 1'b0;
		chk(frame_t'(expl_busy_out), frame_t'(1'b1));
		repeat (20) @(negedge mclk_in);
		cmpq(rcvq, expq);
		cmpq(txq, '{{FR_EXPLICIT, 6'h0c, 11'h000, expl_data_in}});
		$display("test peer filter and explicit done");
		// Slave mode answers polls only
		setup(9'h0a1, 16'h0500);
		link_partner_inst.send(FR_STROBE_REQ, 6'h20, DEST_ALL, 11'h000, strobe_data_in);
		link_partner_inst.send(FR_EXPLICIT, 6'h20, 6'h05, 11'h000, expl_data_in);
		link_partner_inst.send(FR_POLL_REQ, 6'h20, 6'h05, 11'h000, poll_data_in);
		repeat (10) @(negedge mclk_in);
		cmpq(txq, '{{FR_POLL_RSP, 6'h20, 11'h000, slave_data_in}});
		cmpq(rcvq, '{{FR_POLL_REQ, 6'h20, 11'h000, poll_data_in}});
		$display("test slave mode done");
		// Role, type, firmware and switch settings, legal and refused
		for (int t = 0; t < 13; t++) begin
			setup(TC[t], TSW[t]);
			repeat (MS_P + 40) @(negedge mclk_in);
			ok = !TERR[t] && !TSW[t][2];
			bt = TSW[t][7:4] == 4'h0 ? 10'h320 : TSW[t][7:4] == 4'h1 ? 10'h190 : TSW[t][7:4] == 4'h2 ? 10'h0c8 : 10'h000;
			chk({param_error_out, module_network_status_indicator_red_out, module_network_status_indicator_green_out,
				bit_time_cycles_out, txq.size() != 0, node_id_out},
				{TERR[t], TSW[t][2], ok, bt, ok, TSW[t][13:8]});
		end
		$display("test settings table done");
		report_and_stop();
	end
endmodule
